// ==== common/port_pin_pkg.sv ====
// Constants shared by the port pin logic and its register slave
package port_pin_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_MODE_LOW = 8'h04;
	localparam logic [7:0] OFS_MODE_HIGH = 8'h08;
	localparam logic [7:0] OFS_PINS = 8'h0C;
	localparam logic [7:0] OFS_AUX = 8'h10;
	localparam logic [7:0] OFS_CPU_OP = 8'h14;
	localparam logic [7:0] OFS_CPU_RESULT = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int AUX_ADDR_LATCH_OFF_BIT = 0;
	localparam int AUX_PRI_OSC_LSB = 1;
	localparam int AUX_SEC_OSC_LSB = 3;
	localparam int OP_CODE_LSB = 0;
	localparam int OP_BIT_LSB = 4;
	localparam int OP_VALUE_LSB = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [7:0] MODE_LOW_RESET_FUSE = 8'hFF;
	localparam logic [7:0] MODE_LOW_RESET_NOFUSE = 8'h00;
	localparam logic [7:0] MODE_HIGH_RESET = 8'h00;
	localparam logic [4:0] AUX_RESET = 5'h00;

	// ----------------------------------------
	// Pin mode pair {low, high}
	// ----------------------------------------
	localparam logic [1:0] MODE_QUASI = 2'h0;
	localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
	localparam logic [1:0] MODE_INPUT = 2'h2;
	localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

	// ----------------------------------------
	// Oscillator settings
	// ----------------------------------------
	localparam logic [1:0] OSC_CRYSTAL = 2'h0;
	localparam logic [1:0] OSC_EXT_CLOCK = 2'h1;
	localparam logic [1:0] OSC_INT_RC = 2'h2;
	localparam logic [1:0] OSC_DISABLED = 2'h3;

	// ----------------------------------------
	// Pin positions with shared duties
	// ----------------------------------------
	localparam int PIN_SEC_XTAL_OUT = 2;
	localparam int PIN_ADDR_LATCH = 4;
	localparam int PIN_PRI_XTAL_IN = 6;
	localparam int PIN_PRI_XTAL_OUT = 7;

	// CPU port operation codes
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_WRITE = 4'h1,
		OP_AND = 4'h2,
		OP_OR = 4'h3,
		OP_XOR = 4'h4,
		OP_JBC = 4'h5,
		OP_CPL = 4'h6,
		OP_INC = 4'h7,
		OP_DEC = 4'h8,
		OP_DECREMENT_JUMP_NONZERO_OP = 4'h9,
		OP_MOV_C = 4'hA,
		OP_CLR = 4'hB,
		OP_BIT_SET_OP = 4'hC
	} port_op_e;

endpackage

// ==== rtl/port_pin_rmw_altfunc_mux.sv ====
// Port pin logic: read source select, alternate function gating, pin modes
// Operation
// - Plain port read returns pin levels
// - Read-modify-write reads latch, writes latch back
// - Bit writes rewrite all eight latch bits
// - Listed operations are latch-sourced read-modify-write
// - Alternate functions ANDed with latch bit
// - Cleared latch forces function low unless input-only
// - Mode pair and latch give function direction
// - Bit 4 general only while latch-off set
// - Bit 6 general only with internal RC
// - Bit 7 general with RC or external clock
// - Bit 2 general when secondary oscillator freed
// - Mode bits select the output structure
// - Quasi mode strong pull-up one clock
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps

module port_pin_rmw_altfunc_mux #(
	parameter bit TRISTATE_FUSE = 1'b0,
	parameter bit HAS_SEC_OSC = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Port pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] weak_pullup_en,
	// Alternate functions from and to peripherals
	input wire logic [7:0] alt_out,
	input wire logic [7:0] alt_out_en,
	output logic [7:0] alt_in,
	// Dedicated functions sharing pins
	input wire logic addr_latch_enable,
	input wire logic primary_crystal_output,
	input wire logic secondary_crystal_output,
	output logic primary_crystal_input,
	output logic [7:0] pin_general
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] pin_latch_bit_q, pin_latch_bit_d;
	logic [7:0] pin_mode_sel_low_q, pin_mode_sel_low_d;
	logic [7:0] pin_mode_sel_high_q, pin_mode_sel_high_d;
	logic [4:0] auxiliary_control_reg_q, auxiliary_control_reg_d;
	logic [7:0] result_q, result_d;
	logic jump_q, jump_d;
	logic [7:0] strong_q, strong_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic [7:0] pins_q, pins_d;

	// Decoded control fields and the bus request
	logic req;
	logic addr_latch_off;
	logic [1:0] primary_oscillator;
	logic [1:0] secondary_oscillator;
	port_pin_pkg::port_op_e op;
	logic [2:0] op_bit;
	logic [7:0] op_val;

	// Latch and mode registers are one byte wide and live in lane 0
	// Byte lane merge for register writes
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	// Mode pair of one pin
	function automatic logic [1:0] mode_of(input logic [7:0] lo, input logic [7:0] hi, input int i);
		mode_of = {lo[i], hi[i]};
	endfunction

	// Request strobe and decoded fields
	// Ack in the request term keeps one answer per strobe
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign addr_latch_off = auxiliary_control_reg_q[port_pin_pkg::AUX_ADDR_LATCH_OFF_BIT];
	assign primary_oscillator = auxiliary_control_reg_q[port_pin_pkg::AUX_PRI_OSC_LSB +: 2];
	assign secondary_oscillator = auxiliary_control_reg_q[port_pin_pkg::AUX_SEC_OSC_LSB +: 2];
	assign op = port_pin_pkg::port_op_e'(wb_dat_i[port_pin_pkg::OP_CODE_LSB +: 4]);
	assign op_bit = wb_dat_i[port_pin_pkg::OP_BIT_LSB +: 3];
	assign op_val = wb_dat_i[port_pin_pkg::OP_VALUE_LSB +: 8];

	// ----------------------------------------
	// Pin sharing
	// ----------------------------------------
	// Which pins are free for general use
	always_comb
	begin
		pin_general = 8'hFF;
		pin_general[port_pin_pkg::PIN_ADDR_LATCH] = addr_latch_off;
		// A disabled primary oscillator still holds its pins
		pin_general[port_pin_pkg::PIN_PRI_XTAL_IN] =
			primary_oscillator == port_pin_pkg::OSC_INT_RC;
		pin_general[port_pin_pkg::PIN_PRI_XTAL_OUT] = primary_oscillator == port_pin_pkg::OSC_INT_RC
			|| primary_oscillator == port_pin_pkg::OSC_EXT_CLOCK;
		pin_general[port_pin_pkg::PIN_SEC_XTAL_OUT] = !HAS_SEC_OSC
			|| secondary_oscillator != port_pin_pkg::OSC_CRYSTAL;
	end

	// Crystal input is the raw pin while dedicated
	// Parked at 0 while general, so port traffic never reaches the oscillator
	assign primary_crystal_input = pin_general[port_pin_pkg::PIN_PRI_XTAL_IN] ? 1'b0 : pin_in[port_pin_pkg::PIN_PRI_XTAL_IN];

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Output structure per mode, gated alternate functions
	always_comb
	begin
		logic [1:0] m;
		logic drive;
		m = 2'h0;
		drive = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			m = mode_of(pin_mode_sel_low_q, pin_mode_sel_high_q, i);
			// Output value: latch, ANDed with function when peripheral drives
			drive = alt_out_en[i] ? (alt_out[i] & pin_latch_bit_q[i]) : pin_latch_bit_q[i];
			// Input to peripheral: input-only ignores the latch
			alt_in[i] = (m == port_pin_pkg::MODE_INPUT) ? pin_in[i] : (pin_in[i] & pin_latch_bit_q[i]);
			// Port value reaches the pin through the mode's driver
			pin_out[i] = drive;
			// Weak pull-up only in quasi mode, cleared here for the others
			weak_pullup_en[i] = 1'b0;
			unique case (m)
				port_pin_pkg::MODE_QUASI:
				begin
					pin_oe[i] = !drive || strong_q[i];
					weak_pullup_en[i] = drive;
				end
				port_pin_pkg::MODE_PUSH_PULL: pin_oe[i] = 1'b1;
				port_pin_pkg::MODE_INPUT: pin_oe[i] = 1'b0;
				port_pin_pkg::MODE_OPEN_DRAIN: pin_oe[i] = !drive;
			endcase
			// Dedicated duties take the pin over
			// Mode registers are kept, so the pin returns to them when freed
			if (!pin_general[i])
			begin
				if (i == port_pin_pkg::PIN_ADDR_LATCH)
				begin
					pin_out[i] = addr_latch_enable;
					pin_oe[i] = 1'b1;
				end
				else if (i == port_pin_pkg::PIN_PRI_XTAL_OUT)
				begin
					pin_out[i] = primary_crystal_output;
					pin_oe[i] = 1'b1;
				end
				else if (i == port_pin_pkg::PIN_SEC_XTAL_OUT)
				begin
					pin_out[i] = secondary_crystal_output;
					pin_oe[i] = 1'b1;
				end
				else
				begin
					pin_out[i] = 1'b0;
					pin_oe[i] = 1'b0;
				end
				weak_pullup_en[i] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// CPU port operations and register writes
	// ----------------------------------------
	// Next state of latch, modes, result and bus answer
	always_comb
	begin
		logic [7:0] v;
		pin_latch_bit_d = pin_latch_bit_q;
		pin_mode_sel_low_d = pin_mode_sel_low_q;
		pin_mode_sel_high_d = pin_mode_sel_high_q;
		auxiliary_control_reg_d = auxiliary_control_reg_q;
		result_d = result_q;
		jump_d = jump_q;
		// Pin sample lags one clock; plain reads see the previous cycle
		pins_d = pin_in;
		ack_d = req;
		dat_d = 32'h0000_0000;
		// Operand of every modifying operation is the latch, never the pins
		v = pin_latch_bit_q;
		if (req && wb_we_i)
		begin
			unique case (wb_adr_i)
				port_pin_pkg::OFS_LATCH: pin_latch_bit_d = lane0(pin_latch_bit_q, wb_dat_i, wb_sel_i);
				port_pin_pkg::OFS_MODE_LOW: pin_mode_sel_low_d = lane0(pin_mode_sel_low_q, wb_dat_i, wb_sel_i);
				port_pin_pkg::OFS_MODE_HIGH: pin_mode_sel_high_d = lane0(pin_mode_sel_high_q, wb_dat_i, wb_sel_i);
				port_pin_pkg::OFS_AUX:
				begin
					if (wb_sel_i[0])
						auxiliary_control_reg_d = wb_dat_i[4:0];
				end
				port_pin_pkg::OFS_CPU_OP:
				begin
					// Opcode and value lanes must both be enabled, else the request is dropped
					if (wb_sel_i[1:0] == 2'h3)
					begin
						jump_d = 1'b0;
						unique case (op)
							port_pin_pkg::OP_READ: result_d = pins_q;
							port_pin_pkg::OP_WRITE: v = op_val;
							port_pin_pkg::OP_AND: v = v & op_val;
							port_pin_pkg::OP_OR: v = v | op_val;
							port_pin_pkg::OP_XOR: v = v ^ op_val;
							port_pin_pkg::OP_JBC:
							begin
								jump_d = v[op_bit];
								v[op_bit] = 1'b0;
							end
							port_pin_pkg::OP_CPL: v[op_bit] = !v[op_bit];
							port_pin_pkg::OP_INC: v = 8'(v + 8'h01);
							port_pin_pkg::OP_DEC: v = 8'(v - 8'h01);
							port_pin_pkg::OP_DECREMENT_JUMP_NONZERO_OP:
							begin
								v = 8'(v - 8'h01);
								jump_d = v != 8'h00;
							end
							port_pin_pkg::OP_MOV_C: v[op_bit] = op_val[0];
							port_pin_pkg::OP_CLR: v[op_bit] = 1'b0;
							port_pin_pkg::OP_BIT_SET_OP: v[op_bit] = 1'b1;
							// Unknown codes write the latch back unchanged
							default: v = pin_latch_bit_q;
						endcase
						// Whole byte written back, so bit operations rewrite all eight bits
						if (op != port_pin_pkg::OP_READ)
						begin
							pin_latch_bit_d = v;
							result_d = v;
						end
					end
				end
				default: ;
			endcase
		end
		// Register reads; unmapped offsets answer zero
		else if (req)
		begin
			unique case (wb_adr_i)
				port_pin_pkg::OFS_LATCH: dat_d = {24'h000000, pin_latch_bit_q};
				port_pin_pkg::OFS_MODE_LOW: dat_d = {24'h000000, pin_mode_sel_low_q};
				port_pin_pkg::OFS_MODE_HIGH: dat_d = {24'h000000, pin_mode_sel_high_q};
				port_pin_pkg::OFS_PINS: dat_d = {24'h000000, pins_q};
				port_pin_pkg::OFS_AUX: dat_d = {27'h0000000, auxiliary_control_reg_q};
				port_pin_pkg::OFS_CPU_RESULT: dat_d = {23'h000000, jump_q, result_q};
				default: dat_d = 32'h0000_0000;
			endcase
		end
		// Strong pull-up for one clock on a 0 to 1 latch change
		// Taken from the next latch value so the pulse starts with the new level
		strong_d = pin_latch_bit_d & ~pin_latch_bit_q;
	end

	// Register all state
	// Synchronous reset; mode low follows the tristate fuse
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_latch_bit_q <= port_pin_pkg::LATCH_RESET;
			pin_mode_sel_low_q <= TRISTATE_FUSE ? port_pin_pkg::MODE_LOW_RESET_FUSE : port_pin_pkg::MODE_LOW_RESET_NOFUSE;
			pin_mode_sel_high_q <= port_pin_pkg::MODE_HIGH_RESET;
			auxiliary_control_reg_q <= port_pin_pkg::AUX_RESET;
			result_q <= 8'h00;
			jump_q <= 1'b0;
			strong_q <= 8'h00;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			pins_q <= 8'h00;
		end
		else
		begin
			pin_latch_bit_q <= pin_latch_bit_d;
			pin_mode_sel_low_q <= pin_mode_sel_low_d;
			pin_mode_sel_high_q <= pin_mode_sel_high_d;
			auxiliary_control_reg_q <= auxiliary_control_reg_d;
			result_q <= result_d;
			jump_q <= jump_d;
			strong_q <= strong_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
			pins_q <= pins_d;
		end
	end

	// Bus outputs
	// Data stays zero outside the ack cycle
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule

// ==== testbench/port_pin_board.sv ====
// Board model that resolves the pin levels
`timescale 1ns/10ps

module port_pin_board (
	// Device drivers
	input logic [7:0] pin_out,
	input logic [7:0] pin_oe,
	// External source
	input logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	// ----
	// Pins
	// ----
	// Driven bits follow the device, the rest follow the board source
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ==== testbench/port_pin_asserts.sv ====
// Checker for the port pin logic ports
`timescale 1ns/10ps

module port_pin_checker #(
	parameter bit HAS_SEC_OSC = 1'b1
) (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// Register bus
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	// Pins
	input logic [7:0] pin_out,
	input logic [7:0] pin_oe,
	input logic [7:0] weak_pullup_en,
	input logic [7:0] alt_out,
	input logic [7:0] alt_out_en,
	input logic [7:0] pin_in,
	input logic primary_crystal_input,
	input logic [7:0] pin_general,
	// Dedicated sources
	input logic addr_latch_enable,
	input logic primary_crystal_output,
	input logic secondary_crystal_output
);
	// ----
	// Properties
	// ----
	// One clock domain
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Handshake
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack unasked");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data outside ack");
	// Pin sharing and drivers
	gen_change_a: assert property (!$stable(pin_general) |-> wb_ack_o && wb_we_i)
		else $error("pin sharing moved");
	gen_reset_a: assert property ($past(rst) |-> pin_general == (HAS_SEC_OSC ? 8'h2B : 8'h2F))
		else $error("pin sharing after reset");
	xtal_route_a: assert property (primary_crystal_input == (pin_general[6] ? 1'b0 : pin_in[6]))
		else $error("crystal input route");
	addr_route_a: assert property (pin_general[4] || pin_oe[4] && pin_out[4] == addr_latch_enable)
		else $error("address latch routing");
	pri_out_a: assert property (pin_general[7] || pin_oe[7] && pin_out[7] == primary_crystal_output)
		else $error("crystal output routing");
	sec_out_a: assert property (pin_general[2] || pin_oe[2] && pin_out[2] == secondary_crystal_output)
		else $error("second crystal routing");
	alt_zero_a: assert property ((pin_general & alt_out_en & ~alt_out & pin_out) == 8'h00)
		else $error("function not gated");
	weak_drive_a: assert property ((weak_pullup_en & pin_oe & ~pin_out) == 8'h00)
		else $error("pull-up while driving low");
	strong_once_a: assert property ((weak_pullup_en & pin_oe) != 8'h00 |=>
		(weak_pullup_en & pin_oe & $past(weak_pullup_en & pin_oe)) == 8'h00)
		else $error("strong pull-up too long");
	// Scenario reach
	write_c: cover property (wb_ack_o && wb_we_i);
	rise_c: cover property ($rose(pin_oe[0]));
	general_c: cover property (pin_general == 8'hFF);
endmodule

bind port_pin_rmw_altfunc_mux port_pin_checker #(.HAS_SEC_OSC(HAS_SEC_OSC)) chk (.*);

// ==== testbench/port_pin_rmw_altfunc_mux_tb_top.sv ====
// Testbench for the port pin logic
`timescale 1ns/10ps

module port_pin_rmw_altfunc_mux_tb_top;
	logic sys_clk;
	logic rst;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] weak_pullup_en;
	logic [7:0] alt_out;
	logic [7:0] alt_out_en;
	logic [7:0] alt_in;
	logic [7:0] ext_val;
	logic [7:0] pin_general;
	logic [8:0] e;
	logic [3:0] sel_use = 4'hF;
	logic [7:0] oe_at_ack;
	logic [7:0] ax [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h10, 8'h18};
	logic [7:0] gx [8] = '{8'h2B, 8'h3B, 8'hAB, 8'hEB, 8'h2B, 8'h2F, 8'h2F, 8'h2F};
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;

	// ----
	// Parts
	// ----
	// Device and board
	// Dedicated sources follow the cycle count so their routing shows on the pins
	port_pin_rmw_altfunc_mux uut (.*, .addr_latch_enable(cycles[0]),
		.primary_crystal_output(cycles[1]), .secondary_crystal_output(cycles[2]), .primary_crystal_input());
	port_pin_board board (.*);

	// ----
	// Tasks
	// ----
	// Classic bus cycle held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= sel_use;
		wb_dat_i <= d;
		do
		begin
			@(posedge sys_clk);
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		oe_at_ack = pin_oe;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register write and read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	// Expected port operation outcome from latch 2B, value 35, pins C3
	function automatic logic [8:0] rmw(input logic [3:0] op);
		logic [7:0] l;
		logic [7:0] m;
		l = 8'h2B;
		m = 8'h01 << op[2:0];
		case (op)
			4'h0: return {1'b0, 8'hC3};
			4'h1: return {1'b0, 8'h35};
			4'h2: return {1'b0, l & 8'h35};
			4'h3: return {1'b0, l | 8'h35};
			4'h4: return {1'b0, l ^ 8'h35};
			4'h5: return {|(l & m), l & ~m};
			4'h6: return {1'b0, l ^ m};
			4'h7: return {1'b0, l + 8'h01};
			4'h8, 4'h9: return {op[0] && l != 8'h01, l - 8'h01};
			4'hA, 4'hC: return {1'b0, l | m};
			4'hB: return {1'b0, l & ~m};
			default: return {1'b0, l};
		endcase
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----
	// Run
	// ----
	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever
		begin
			#2 sys_clk = ~sys_clk;
		end
	end

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			miscompares++;
			test_done();
		end
	end

	// Tests
	initial
	begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
		{alt_out, alt_out_en} = 16'h0;
		wb_sel_i = 4'h0;
		ext_val = 8'hC3;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(port_pin_pkg::OFS_LATCH, 32'hFF);
		rd(port_pin_pkg::OFS_MODE_LOW, 32'h0);
		rd(port_pin_pkg::OFS_MODE_HIGH, 32'h0);
		rd(port_pin_pkg::OFS_AUX, 32'h0);
		rd(8'h1C, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 8; i++)
		begin
			wr(port_pin_pkg::OFS_AUX, {24'h0, ax[i]});
			chk({24'h0, pin_general}, {24'h0, gx[i]});
		end
		wr(port_pin_pkg::OFS_AUX, 32'h1D);
		rd(port_pin_pkg::OFS_AUX, 32'h1D);
		$display("sharing test done");
		for (int m = 0; m < 4; m++)
		begin
			wr(port_pin_pkg::OFS_MODE_LOW, {24'h0, {8{m[1]}}});
			wr(port_pin_pkg::OFS_MODE_HIGH, {24'h0, {8{m[0]}}});
			wr(port_pin_pkg::OFS_LATCH, 32'h00);
			chk({pin_oe, weak_pullup_en}, {16'h0, (m == 2 ? 8'h00 : 8'hFF), 8'h00});
			wr(port_pin_pkg::OFS_LATCH, 32'hFF);
			chk({24'h0, oe_at_ack}, {24'h0, (m < 2 ? 8'hFF : 8'h00)});
			chk({pin_oe, weak_pullup_en}, {16'h0, (m == 1 ? 8'hFF : 8'h00), (m == 0 ? 8'hFF : 8'h00)});
		end
		$display("mode test done");
		wr(port_pin_pkg::OFS_MODE_LOW, 32'hFF);
		wr(port_pin_pkg::OFS_MODE_HIGH, 32'h00);
		rd(port_pin_pkg::OFS_PINS, 32'hC3);
		for (int op = 0; op < 14; op++)
		begin
			e = rmw(op[3:0]);
			wr(port_pin_pkg::OFS_LATCH, 32'h2B);
			wr(port_pin_pkg::OFS_CPU_OP, {16'h0, 8'h35, 1'b0, op[2:0], op[3:0]});
			if (op < 13)
				rd(port_pin_pkg::OFS_CPU_RESULT, {23'h0, e});
			rd(port_pin_pkg::OFS_LATCH, {24'h0, (op == 0 ? 8'h2B : e[7:0])});
		end
		sel_use = 4'h1;
		wr(port_pin_pkg::OFS_CPU_OP, 32'h0000_3501);
		sel_use = 4'hF;
		rd(port_pin_pkg::OFS_LATCH, 32'h2B);
		$display("operation test done");
		wr(port_pin_pkg::OFS_MODE_LOW, 32'h00);
		wr(port_pin_pkg::OFS_MODE_HIGH, 32'hFF);
		wr(port_pin_pkg::OFS_LATCH, 32'h0F);
		alt_out <= 8'hAA;
		alt_out_en <= 8'hFF;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk({pin_out, alt_in}, 32'h0A0A);
		wr(port_pin_pkg::OFS_MODE_LOW, 32'hFF);
		wr(port_pin_pkg::OFS_MODE_HIGH, 32'h00);
		wr(port_pin_pkg::OFS_LATCH, 32'h00);
		chk({24'h0, alt_in}, 32'hC3);
		$display("function test done");
		test_done();
	end
endmodule
